// ===== hdl/iesc_ctrl.v
// How it works
// - disabling clears bus status, start-failed, busy and line level bits
// - writing exit abandons the transfer and enters standby
// - the exit bit clears itself once the exit is done
// - an exit releases both bus lines
// - an exit clears start, stop requests and the bus status flags except the stop-detected flag
// - standby lasts until a stop, or an address match or extension code
// - writing wait release cancels the wait; the bit clears itself
// - a stop raises an interrupt only when the stop enable is set
// - timing select picks the eighth or ninth clock fall for wait and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "iesc_map.vh"
module iesc_ctrl (
   input  wire        i_clock,    // System clock, 20 MHz
   input  wire        i_arst_n,   // Async reset, active low
   input  wire        i_clk_en,   // Freezes all state while low
   input  wire        i_psel,     // APB select
   input  wire        i_penable,  // APB enable
   input  wire        i_pwrite,   // APB direction, high for write
   input  wire [7:0]  i_paddr,    // APB byte address
   input  wire [31:0] i_pwdata,   // APB write data
   output wire [31:0] o_prdata,   // APB read data
   output wire        o_pready,   // APB ready
   output wire        o_pslverr,  // APB error on unmapped address
   input  wire        i_scl,      // Clock line level
   output wire        o_scl,      // Clock line drive value
   output wire        o_scl_oe,   // Clock line driven low when high
   input  wire        i_sda,      // Data line level
   output wire        o_sda,      // Data line drive value
   output wire        o_sda_oe,   // Data line driven low when high
   output wire        o_irq       // Level interrupt
);

   wire       scl_lvl;
   wire       sda_lvl;
   reg        scl_prev_ff;
   reg        sda_prev_ff;
   // Control fields
   reg        en_ff;
   reg        exit_ff;
   reg        wrel_ff;
   reg        spie_ff;
   reg        wtim_ff;
   reg        acke_ff;
   reg        stt_ff;
   reg        spt_ff;
   reg  [7:0] saddr_ff;
   // Bus status and flags
   reg        msts_ff;
   reg        exc_ff;
   reg        coi_ff;
   reg        trc_ff;
   reg        ackd_ff;
   reg        std_ff;
   reg        spd_ff;
   reg        stcf_ff;
   reg        bsy_ff;
   reg        stby_ff;
   reg        cld_ff;
   reg        dad_ff;
   // Protocol tracking
   reg  [3:0] cnt_ff;
   reg  [7:0] shift_ff;
   reg        first_ff;
   reg        wait_ff;
   reg        ack_ff;
   // Interrupts and bus
   reg  [1:0] irq_stat_ff;
   reg  [1:0] irq_mask_ff;
   reg [31:0] prdata_ff;
   reg [31:0] nxt_rdata;
   reg        map_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   iesc_sync #(.RESET_VAL(1'b1)) u_sync_scl (
      .i_clock  (i_clock),
      .i_arst_n (i_arst_n),
      .i_clk_en (i_clk_en),
      .i_async  (i_scl),
      .o_level  (scl_lvl)
   );

   iesc_sync #(.RESET_VAL(1'b1)) u_sync_sda (
      .i_clock  (i_clock),
      .i_arst_n (i_arst_n),
      .i_clk_en (i_clk_en),
      .i_async  (i_sda),
      .o_level  (sda_lvl)
   );

   // Line edges and bus conditions
   wire scl_rise  = scl_lvl & ~scl_prev_ff;
   wire scl_fall  = ~scl_lvl & scl_prev_ff;
   wire start_det = en_ff & scl_lvl & scl_prev_ff & sda_prev_ff & ~sda_lvl;
   wire stop_det  = en_ff & scl_lvl & scl_prev_ff & ~sda_prev_ff & sda_lvl;

   // Clock counts within a byte; no byte counting outside a frame
   wire fall8    = en_ff & bsy_ff & scl_fall & (cnt_ff == `IESC_CNT_EIGHTH);
   wire fall9    = en_ff & bsy_ff & scl_fall & (cnt_ff == `IESC_CNT_NINTH);
   wire addr_hit = fall8 & first_ff & (shift_ff[7:1] == saddr_ff[7:1]);
   wire ext_hit  = fall8 & first_ff & (shift_ff[7:3] == `IESC_EXT_CODE);
   wire part     = msts_ff | coi_ff | exc_ff | addr_hit | ext_hit;
   wire wait_pt  = wtim_ff ? fall9 : fall8;
   wire wait_evt = wait_pt & part & ~exit_ff;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states
   wire apb_setup = i_psel & ~i_penable;
   wire apb_done  = i_psel & i_penable;
   wire wr        = apb_done & i_pwrite;
   wire rd        = apb_done & ~i_pwrite;
   wire wr_ctrl   = wr & (i_paddr == `IESC_ADDR_CTRL);
   wire rd_irq    = rd & (i_paddr == `IESC_ADDR_IRQ_STAT);

   // Read mux, sampled in the setup phase
   always @* begin
      nxt_rdata = 32'h0000_0000;
      map_hit   = 1'b1;
      case (i_paddr)
         `IESC_ADDR_CTRL: begin
            nxt_rdata[7:0] = {en_ff, exit_ff, wrel_ff, spie_ff,
                              wtim_ff, acke_ff, stt_ff, spt_ff};
         end
         `IESC_ADDR_SADDR: begin
            nxt_rdata[7:0] = saddr_ff;
         end
         `IESC_ADDR_LINE: begin
            nxt_rdata[`IESC_LINE_CLD] = cld_ff;
            nxt_rdata[`IESC_LINE_DAD] = dad_ff;
         end
         `IESC_ADDR_STAT: begin
            nxt_rdata[7:0] = {msts_ff, 1'b0, exc_ff, coi_ff,
                              trc_ff, ackd_ff, std_ff, spd_ff};
         end
         `IESC_ADDR_FLAG: begin
            nxt_rdata[`IESC_FLAG_STCF] = stcf_ff;
            nxt_rdata[`IESC_FLAG_BSY]  = bsy_ff;
            nxt_rdata[`IESC_FLAG_STBY] = stby_ff;
         end
         `IESC_ADDR_IRQ_STAT: begin
            nxt_rdata[1:0] = irq_stat_ff;
         end
         `IESC_ADDR_IRQ_MASK: begin
            nxt_rdata[1:0] = irq_mask_ff;
         end
         default: begin
            map_hit = 1'b0;
         end
      endcase
   end

   // Read data register; held through the access phase
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (i_clk_en && apb_setup && !i_pwrite) begin
         prdata_ff <= nxt_rdata;
      end
   end

   assign o_prdata  = prdata_ff;
   assign o_pready  = 1'b1;
   assign o_pslverr = apb_done & ~map_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Control register; action bits clear themselves one cycle after use
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         {en_ff, exit_ff, wrel_ff, spie_ff,
          wtim_ff, acke_ff, stt_ff, spt_ff} <= `IESC_RST_CTRL;
         saddr_ff    <= `IESC_RST_SADDR;
         irq_mask_ff <= `IESC_RST_MASK;
      end else if (i_clk_en) begin
         if (wr_ctrl) begin
            en_ff   <= i_pwdata[`IESC_CTRL_EN];
            spie_ff <= i_pwdata[`IESC_CTRL_SPIE];
            wtim_ff <= i_pwdata[`IESC_CTRL_WTIM];
            acke_ff <= i_pwdata[`IESC_CTRL_ACKE];
         end
         if (wr_ctrl) begin
            exit_ff <= i_pwdata[`IESC_CTRL_EXIT];
         end else if (exit_ff) begin
            exit_ff <= 1'b0;
         end
         if (wr_ctrl) begin
            wrel_ff <= i_pwdata[`IESC_CTRL_WREL];
         end else if (wrel_ff) begin
            wrel_ff <= 1'b0;
         end
         // Requests: exit and disable clear them
         if (exit_ff || !en_ff) begin
            stt_ff <= 1'b0;
            spt_ff <= 1'b0;
         end else if (wr_ctrl) begin
            stt_ff <= i_pwdata[`IESC_CTRL_STT];
            spt_ff <= i_pwdata[`IESC_CTRL_SPT];
         end else begin
            if (stt_ff) begin
               stt_ff <= 1'b0; // Taken or refused at once
            end
            if (spt_ff && (stop_det || !msts_ff)) begin
               spt_ff <= 1'b0;
            end
         end
         if (wr && (i_paddr == `IESC_ADDR_SADDR)) begin
            saddr_ff <= i_pwdata[7:0];
         end
         if (wr && (i_paddr == `IESC_ADDR_IRQ_MASK)) begin
            irq_mask_ff <= i_pwdata[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus tracking, status flags and standby
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
         {msts_ff, exc_ff, coi_ff, trc_ff, ackd_ff, std_ff, spd_ff} <= 7'h00;
         {stcf_ff, bsy_ff, stby_ff, cld_ff, dad_ff} <= 5'h00;
         cnt_ff   <= 4'h0;
         shift_ff <= 8'h00;
         first_ff <= 1'b0;
         wait_ff  <= 1'b0;
         ack_ff   <= 1'b0;
      end else if (i_clk_en) begin
         scl_prev_ff <= scl_lvl;
         sda_prev_ff <= sda_lvl;
         if (!en_ff) begin
            // Disabled: status, busy, start-failed and line levels read zero
            {msts_ff, exc_ff, coi_ff, trc_ff, ackd_ff, std_ff, spd_ff} <= 7'h00;
            {stcf_ff, bsy_ff, stby_ff, cld_ff, dad_ff} <= 5'h00;
            cnt_ff   <= 4'h0;
            first_ff <= 1'b0;
            wait_ff  <= 1'b0;
            ack_ff   <= 1'b0;
         end else begin
            cld_ff <= scl_lvl;
            dad_ff <= sda_lvl;
            // Byte framing from the line edges
            if (start_det) begin
               cnt_ff   <= 4'h0;
               first_ff <= 1'b1;
               bsy_ff   <= 1'b1;
               std_ff   <= 1'b1;
               spd_ff   <= 1'b0;
            end else if (stop_det) begin
               cnt_ff   <= 4'h0;
               first_ff <= 1'b0;
               bsy_ff   <= 1'b0;
               spd_ff   <= 1'b1;
            end else if (bsy_ff && scl_rise) begin
               if (cnt_ff < `IESC_CNT_EIGHTH) begin
                  shift_ff <= {shift_ff[6:0], sda_lvl};
               end
               if (cnt_ff == `IESC_CNT_EIGHTH) begin
                  ackd_ff <= part & ~sda_lvl;
               end
               cnt_ff <= cnt_ff + 4'h1;
            end else if (fall9) begin
               cnt_ff   <= 4'h0;
               first_ff <= 1'b0;
            end
            // Master role taken by a start request on a free bus
            if (stt_ff && !exit_ff) begin
               if (bsy_ff) begin
                  stcf_ff <= 1'b1;
               end else begin
                  msts_ff <= 1'b1;
                  stcf_ff <= 1'b0;
               end
            end
            if (addr_hit) begin
               coi_ff <= 1'b1;
               trc_ff <= shift_ff[0];
            end
            if (ext_hit) begin
               exc_ff <= 1'b1;
            end
            if (fall8 && first_ff && !addr_hit && !ext_hit) begin
               coi_ff <= 1'b0;
               exc_ff <= 1'b0;
            end
            if (stop_det) begin
               {msts_ff, exc_ff, coi_ff, trc_ff, ackd_ff} <= 5'h00;
            end
            // Acknowledge drive on the ninth clock when addressed
            if (fall8 && (addr_hit || (coi_ff && !trc_ff)) && acke_ff) begin
               ack_ff <= 1'b1;
            end else if (fall9) begin
               ack_ff <= 1'b0;
            end
            // Wait holds the clock low until cancelled
            if (wait_evt) begin
               wait_ff <= 1'b1;
            end else if (wrel_ff) begin
               wait_ff <= 1'b0;
            end
            // Leaving standby; a stop or new match ends it
            if (stop_det || addr_hit || ext_hit) begin
               stby_ff <= 1'b0;
            end
            // Exit wins over everything above
            if (exit_ff) begin
               {msts_ff, exc_ff, coi_ff, trc_ff, ackd_ff, std_ff} <= 6'h00;
               stby_ff  <= 1'b1;
               wait_ff  <= 1'b0;
               ack_ff   <= 1'b0;
               first_ff <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Open-drain drive; nothing is driven in standby or after an exit
   assign o_scl    = 1'b0;
   assign o_sda    = 1'b0;
   assign o_scl_oe = wait_ff & ~stby_ff;
   assign o_sda_oe = ack_ff & ~stby_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky events; only bits already seen by the read are cleared, so a
   // set in the same cycle as the clear survives
   wire [1:0] irq_set = {stop_det & spie_ff, wait_evt};

   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_stat_ff <= 2'h0;
      end else if (i_clk_en) begin
         if (rd_irq) begin
            irq_stat_ff <= (irq_stat_ff & ~prdata_ff[1:0]) | irq_set;
         end else begin
            irq_stat_ff <= irq_stat_ff | irq_set;
         end
      end
   end

   assign o_irq = |(irq_stat_ff & irq_mask_ff);

endmodule
`default_nettype wire

// ===== hdl/iesc_sync.v
`timescale 1ns/100ps
`default_nettype none
module iesc_sync #(
   parameter RESET_VAL = 1'b1
) (
   input  wire i_clock,   // System clock
   input  wire i_arst_n,  // Async reset, active low
   input  wire i_clk_en,  // Freezes state while low
   input  wire i_async,   // Pin level from outside the domain
   output wire o_level    // Filtered level
);

   reg meta_ff;
   reg s2_ff;
   reg s3_ff;
   reg level_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Three stages; only the second reads the first, to keep metastability out
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_ff  <= RESET_VAL;
         s2_ff    <= RESET_VAL;
         s3_ff    <= RESET_VAL;
         level_ff <= RESET_VAL;
      end else if (i_clk_en) begin
         meta_ff <= i_async;
         s2_ff   <= meta_ff;
         s3_ff   <= s2_ff;
         if (s2_ff == s3_ff) begin // Change counts once stages two and three agree
            level_ff <= s3_ff;
         end
      end
   end

   assign o_level = level_ff;

endmodule
`default_nettype wire

// ===== inc/iesc_map.vh
`ifndef IESC_MAP_VH
`define IESC_MAP_VH
// Register byte addresses (index times four where an index exists)
`define IESC_ADDR_CTRL      8'h08
`define IESC_ADDR_SADDR     8'h0C
`define IESC_ADDR_LINE      8'h10
`define IESC_ADDR_STAT      8'h18
`define IESC_ADDR_FLAG      8'h28
`define IESC_ADDR_IRQ_STAT  8'h40
`define IESC_ADDR_IRQ_MASK  8'h44
// Control register fields
`define IESC_CTRL_EN        7
`define IESC_CTRL_EXIT      6
`define IESC_CTRL_WREL      5
`define IESC_CTRL_SPIE      4
`define IESC_CTRL_WTIM      3
`define IESC_CTRL_ACKE      2
`define IESC_CTRL_STT       1
`define IESC_CTRL_SPT       0
// Bus status register fields
`define IESC_STAT_MSTS      7
`define IESC_STAT_EXC       5
`define IESC_STAT_COI       4
`define IESC_STAT_TRC       3
`define IESC_STAT_ACKD      2
`define IESC_STAT_STD       1
`define IESC_STAT_SPD       0
// Flag register fields
`define IESC_FLAG_STCF      7
`define IESC_FLAG_BSY       6
`define IESC_FLAG_STBY      0
// Line level register fields
`define IESC_LINE_CLD       5
`define IESC_LINE_DAD       4
// Interrupt status and mask fields
`define IESC_IRQ_XFER       0
`define IESC_IRQ_STOP       1
// Reset values
`define IESC_RST_CTRL       8'h00
`define IESC_RST_SADDR      8'h00
`define IESC_RST_MASK       2'h0
// Clock counts within a byte
`define IESC_CNT_EIGHTH     4'h8
`define IESC_CNT_NINTH      4'h9
// Extension code: upper five bits of the first byte
`define IESC_EXT_CODE       5'h01
`endif

// ===== verif/i2c_exit_wait_stop_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "iesc_map.vh"
module i2c_exit_wait_stop_control_bench;
   localparam logic [7:0] OWN_ADDR = 8'hA4;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   wire  [31:0] prdata;
   wire         pready, pslverr, scl_v, sda_v, scl_oe, sda_oe, irq, scl_low, sda_low;
   int          failures = 0;
   int          n_checks = 0;
   // Open-drain wires with pull-ups
   wire scl = !(scl_low || scl_oe);
   wire sda = !(sda_low || sda_oe);
   always #25 clock = ~clock;
   iesc_ctrl u_iesc_ctrl (.i_clock(clock), .i_arst_n(arst_n), .i_clk_en(1'b1), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .o_scl(scl_v),
      .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(sda_v), .o_sda_oe(sda_oe), .o_irq(irq));
   iesc_bus_master u_iesc_bus_master (.i_scl(scl), .o_scl_low(scl_low), .o_sda_low(sda_low));
   ////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h00_0000, d}, r, e);
   endtask
   // Masked read compare
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r & {24'h00_0000, m}, {24'h00_0000, x});
   endtask
   task automatic wait_oe(input logic v);
      int n;
      n = 0;
      while (scl_oe !== v && n < 400) begin
         @(posedge clock);
         n++;
      end
      chk({31'h0, scl_oe}, {31'h0, v});
      if (scl_oe !== v)
         wrap_up();
   endtask
   task automatic frame();
      u_iesc_bus_master.start_cond();
      u_iesc_bus_master.send_byte(OWN_ADDR);
   endtask
   ////////////////////////////////////////
   task automatic s_reset();
      logic [31:0] r;
      logic e;
      rd(`IESC_ADDR_CTRL, 8'hFF, 8'h00);
      apb(1'b0, 8'h3C, 32'h0000_0000, r, e);
      chk(r, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
   endtask
   // Wait at ninth fall, released by software; release without a wait
   task automatic s_wait();
      wr(`IESC_ADDR_SADDR, OWN_ADDR);
      wr(`IESC_ADDR_CTRL, 8'h88);
      frame();
      wait_oe(1'b1);
      rd(`IESC_ADDR_IRQ_STAT, 8'h01, 8'h01);
      wr(`IESC_ADDR_CTRL, 8'hA8);
      wait_oe(1'b0);
      rd(`IESC_ADDR_CTRL, 8'hFF, 8'h88);
      wr(`IESC_ADDR_CTRL, 8'hA8);
      repeat (8) @(posedge clock);
      chk({31'h0, scl_oe}, 32'h0000_0000);
      rd(`IESC_ADDR_CTRL, 8'hFF, 8'h88);
      u_iesc_bus_master.stop_cond();
      repeat (8) @(posedge clock);
      rd(`IESC_ADDR_IRQ_STAT, 8'h02, 8'h00);
   endtask
   // Timing select 0: wait comes at the eighth fall, before the frame is done
   task automatic s_early();
      logic sent;
      sent = 1'b0;
      wr(`IESC_ADDR_CTRL, 8'h80);
      fork
         begin
            frame();
            sent = 1'b1;
         end
         begin
            wait_oe(1'b1);
            chk({31'h0, sent}, 32'h0000_0000);
            rd(`IESC_ADDR_IRQ_STAT, 8'h01, 8'h01);
            wr(`IESC_ADDR_CTRL, 8'hA0);
            wait_oe(1'b0);
         end
      join
      u_iesc_bus_master.stop_cond();
   endtask
   // Software drops out mid transfer, then a stop brings it back
   task automatic s_exit();
      wr(`IESC_ADDR_IRQ_MASK, 8'h02);
      wr(`IESC_ADDR_CTRL, 8'h98);
      frame();
      wait_oe(1'b1);
      wr(`IESC_ADDR_CTRL, 8'hD8);
      wait_oe(1'b0);
      chk({31'h0, sda_oe}, 32'h0000_0000);
      rd(`IESC_ADDR_STAT, 8'hFE, 8'h00);
      rd(`IESC_ADDR_CTRL, 8'hFF, 8'h98);
      rd(`IESC_ADDR_FLAG, 8'h01, 8'h01);
      u_iesc_bus_master.stop_cond();
      repeat (8) @(posedge clock);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(`IESC_ADDR_FLAG, 8'h01, 8'h00);
      rd(`IESC_ADDR_IRQ_STAT, 8'h02, 8'h02);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h0000_0000);
   endtask
   // Disable while holding the bus in a wait
   task automatic s_disable();
      wr(`IESC_ADDR_CTRL, 8'h88);
      frame();
      wait_oe(1'b1);
      wr(`IESC_ADDR_CTRL, 8'h00);
      wait_oe(1'b0);
      rd(`IESC_ADDR_STAT, 8'hFF, 8'h00);
      rd(`IESC_ADDR_FLAG, 8'hC0, 8'h00);
      rd(`IESC_ADDR_LINE, 8'h30, 8'h00);
      u_iesc_bus_master.stop_cond();
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock); // Line synchronisers settle
      s_reset();
      s_wait();
      s_early();
      s_exit();
      s_disable();
      wrap_up();
   end
   // Hang guard, counted as a mismatch
   initial begin
      #500000;
      failures++;
      wrap_up();
   end
endmodule
`default_nettype wire

// ===== verif/iesc_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module iesc_bus_master (
   input  wire logic i_scl,     // Resolved clock line
   output var logic  o_scl_low, // Pulls clock line low
   output var logic  o_sda_low  // Pulls data line low
);
   ////////////////////////////////////////
   // Both lines released at start; the pull-up gives the idle level
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end
   // Release clock, honour stretching; bounded so a stuck line cannot hang us
   // Looks one step after release, so the line value is no longer stale
   task automatic scl_release();
      int n;
      o_scl_low = 1'b0;
      n = 0;
      do begin
         #1;
         n++;
      end while (i_scl !== 1'b1 && n < 250000);
   endtask
   // One 400 ns clock: high 200 (1 spent on the release check), then low
   task automatic scl_pulse();
      scl_release();
      #199;
      o_scl_low = 1'b1;
      #100;
   endtask
   task automatic start_cond();
      o_sda_low = 1'b1;
      #200;
      o_scl_low = 1'b1;
      #100;
   endtask
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         o_sda_low = !b[i];
         #100;
         scl_pulse();
      end
      o_sda_low = 1'b0; // Acknowledge slot left to the addressed node
      #100;
      scl_pulse();
   endtask
   task automatic stop_cond();
      o_sda_low = 1'b1;
      #100;
      scl_release();
      #200;
      o_sda_low = 1'b0;
      #400;
   endtask
endmodule
`default_nettype wire

// ===== verif/iesc_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "iesc_map.vh"
module iesc_ctrl_chk (
   input wire logic        i_clock,   // System clock
   input wire logic        i_arst_n,  // Async reset, active low
   input wire logic        i_psel,    // APB select
   input wire logic        i_penable, // APB enable
   input wire logic        i_pwrite,  // APB direction
   input wire logic [7:0]  i_paddr,   // APB address
   input wire logic [31:0] i_pwdata,  // APB write data
   input wire logic [31:0] o_prdata,  // APB read data
   input wire logic        o_pready,  // APB ready
   input wire logic        o_pslverr, // APB error
   input wire logic        i_scl,     // Clock line level
   input wire logic        o_scl,     // Clock drive value
   input wire logic        o_scl_oe,  // Clock pull enable
   input wire logic        o_sda,     // Data drive value
   input wire logic        o_sda_oe,  // Data pull enable
   input wire logic        o_irq      // Interrupt
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   ////////////////////////////////////////
   // Decoded bus events
   wire acc     = i_psel && i_penable;
   wire wr_ctrl = acc && i_pwrite && (i_paddr == `IESC_ADDR_CTRL);
   wire mapped  = i_paddr inside {8'h08, 8'h0C, 8'h10, 8'h18, 8'h28, 8'h40, 8'h44};
   // Saturating age of the last control write, so old writes never alias
   logic [2:0] since_ff;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n)
         since_ff <= 3'h0;
      else if (wr_ctrl)
         since_ff <= 3'h0;
      else if (since_ff != 3'h7)
         since_ff <= since_ff + 3'h1;
   end
   ////////////////////////////////////////
   a_ready_always: assert property (o_pready) else $error("pready low");
   a_err_unmapped: assert property (acc |-> o_pslverr == !mapped) else $error("pslverr wrong");
   a_lines_zero: assert property (!o_scl && !o_sda) else $error("line value high");
   a_exit_frees: assert property (wr_ctrl && i_pwdata[6] |-> ##[1:3] (!o_scl_oe && !o_sda_oe))
      else $error("exit kept a line");
   a_off_frees: assert property (wr_ctrl && !i_pwdata[7] |-> ##[1:3] (!o_scl_oe && !o_sda_oe))
      else $error("disable kept a line");
   a_wrel_frees: assert property (wr_ctrl && i_pwdata[5] && o_scl_oe |-> ##[1:3] !o_scl_oe)
      else $error("wait not released");
   a_ctrl_selfclr: assert property (acc && !i_pwrite && i_paddr == `IESC_ADDR_CTRL
      && since_ff >= 3'h4 |-> o_prdata[6:5] == 2'b00) else $error("self clear bit stuck");
   a_wait_after_fall: assert property ($rose(o_scl_oe) |-> $past(i_scl, 3) == 1'b0)
      else $error("wait without clock fall");
   c_wait: cover property ($rose(o_scl_oe));
   c_exit: cover property (wr_ctrl && i_pwdata[6]);
   c_irq: cover property ($rose(o_irq));
endmodule
bind iesc_ctrl iesc_ctrl_chk u_chk (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_scl(i_scl),
   .o_scl(o_scl), .o_scl_oe(o_scl_oe), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_irq(o_irq));
`default_nettype wire
